// >>> inc/iam_pkg.sv
// shared constants and types for the indirect address mapper
package iam_pkg;

    // widths
    localparam int PTR_W  = 16;
    localparam int DADR_W = 12;
    localparam int PADR_W = 15;
    localparam int PDAT_W = 14;
    localparam int DATA_W = 8;

    // pointer region bounds
    localparam logic [15:0] TRAD_LAST = 16'h0fff;
    localparam logic [15:0] LIN_FIRST = 16'h2000;
    localparam logic [15:0] LIN_LAST  = 16'h29af;

    // banked layout of general purpose ram
    localparam logic [6:0]  GPR_FIRST = 7'h20;
    localparam logic [11:0] GPR_BYTES = 12'h050;

    // in-bank offsets of the two indirect data ports
    localparam logic [6:0] IND_PORT0 = 7'h00;
    localparam logic [6:0] IND_PORT1 = 7'h01;

    // value returned for self reference and unimplemented space
    localparam logic [7:0] ZERO_DATA = 8'h00;

    // extra cycles for a flash access
    localparam int FLASH_EXTRA = 1;

    // regions of the pointer space
    typedef enum logic [1:0] {
        IAM_RG_TRAD,
        IAM_RG_LIN,
        IAM_RG_PFM,
        IAM_RG_NONE
    } iam_region_e;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_FLASH_WAIT,
        ST_RESP
    } iam_state_e;

    // result of decoding one pointer
    typedef struct packed {
        iam_region_e        region;
        logic               self_ref;
        logic [DADR_W-1:0]  daddr;
        logic [PADR_W-1:0]  paddr;
    } iam_decode_s;

    // access request from the core
    typedef struct packed {
        logic               valid;
        logic               wr;
        logic               sel;
        logic [DATA_W-1:0]  wdata;
    } iam_req_s;

    // join a pointer pair into one address
    function automatic logic [PTR_W-1:0] ptr_join(input logic [7:0] hi, input logic [7:0] lo);
        ptr_join = {hi, lo};
    endfunction

endpackage

// >>> design/iam_lin_map.sv
// linear region pointer to banked data address translation
`timescale 1ns/1ps
module iam_lin_map (
    // pointer in
    input  wire logic [15:0] i_ptr,
    // banked absolute address out
    output logic      [11:0] o_daddr
);
    logic [11:0] offset;
    logic [11:0] bank;
    logic [11:0] in_bank;

    // offset, bank and position within the bank's ram block
    always_comb begin
        offset  = 12'(i_ptr - iam_pkg::LIN_FIRST);
        bank    = offset / iam_pkg::GPR_BYTES;
        in_bank = offset % iam_pkg::GPR_BYTES;
        o_daddr = {bank[4:0], 7'(iam_pkg::GPR_FIRST + in_bank[6:0])};
    end

endmodule

// >>> design/iam_region_dec.sv
// classifies a pointer into its region and address
`timescale 1ns/1ps
module iam_region_dec (
    // pointer and its linear translation
    input  wire logic [15:0]         i_ptr,
    input  wire logic [11:0]         i_lin_daddr,
    // decode result
    output iam_pkg::iam_decode_s     o_dec
);
    // region select, top bit first
    always_comb begin
        o_dec          = '0;
        o_dec.region   = iam_pkg::IAM_RG_NONE;
        o_dec.paddr    = i_ptr[14:0];
        if (i_ptr[15]) begin
            o_dec.region = iam_pkg::IAM_RG_PFM;
        end else if (i_ptr <= iam_pkg::TRAD_LAST) begin
            o_dec.region   = iam_pkg::IAM_RG_TRAD;
            o_dec.daddr    = i_ptr[11:0];
            o_dec.self_ref = (i_ptr[6:0] == iam_pkg::IND_PORT0) ||
                             (i_ptr[6:0] == iam_pkg::IND_PORT1);
        end else if (i_ptr >= iam_pkg::LIN_FIRST && i_ptr <= iam_pkg::LIN_LAST) begin
            o_dec.region = iam_pkg::IAM_RG_LIN;
            o_dec.daddr  = i_lin_daddr;
        end
    end

endmodule

// >>> design/iam_mapper.sv
// indirect data port address mapper and access sequencer
`timescale 1ns/1ps
module iam_mapper (
    // clock and reset
    input  wire logic                i_clock,
    input  wire logic                i_rst,
    // pointer pairs from the core
    input  wire logic [1:0][7:0]     i_pointer_high_byte,
    input  wire logic [1:0][7:0]     i_pointer_low_byte,
    // access request from the core
    input  wire iam_pkg::iam_req_s   i_req,
    // answer to the core
    output logic                     o_busy,
    output logic                     o_stall,
    output logic                     o_done,
    output logic [7:0]               o_rdata,
    // data memory port
    output logic                     o_dmem_req,
    output logic                     o_dmem_wr,
    output logic [11:0]              o_dmem_addr,
    output logic [7:0]               o_dmem_wdata,
    input  wire logic [7:0]          i_dmem_rdata,
    // program flash read port
    output logic                     o_pfm_req,
    output logic [14:0]              o_pfm_addr,
    input  wire logic [13:0]         i_pfm_rdata
);
    iam_pkg::iam_state_e  state_r;
    iam_pkg::iam_decode_s dec;
    iam_pkg::iam_decode_s dec_r;
    logic [15:0]          ptr;
    logic [11:0]          lin_daddr;
    logic                 accept;
    logic                 wr_r;
    logic                 busy_r;
    logic                 stall_r;
    logic                 done_r;
    logic [7:0]           rdata_r;
    logic                 dmem_req_r;
    logic                 dmem_wr_r;
    logic [11:0]          dmem_addr_r;
    logic [7:0]           dmem_wdata_r;
    logic                 pfm_req_r;
    logic [14:0]          pfm_addr_r;
    logic                 data_hit;

    // pointer of the selected pair
    assign ptr    = iam_pkg::ptr_join(i_pointer_high_byte[i_req.sel],
                                      i_pointer_low_byte[i_req.sel]);
    assign accept = i_req.valid && (state_r == iam_pkg::ST_IDLE);

    // linear region translation
    iam_lin_map u_lin (
        .i_ptr   (ptr),
        .o_daddr (lin_daddr)
    );

    // region decode
    iam_region_dec u_dec (
        .i_ptr       (ptr),
        .i_lin_daddr (lin_daddr),
        .o_dec       (dec)
    );

    // a request that really touches data memory
    assign data_hit = !dec.self_ref &&
                      (dec.region == iam_pkg::IAM_RG_TRAD ||
                       dec.region == iam_pkg::IAM_RG_LIN);

    // sequencer
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_r <= iam_pkg::ST_IDLE;
        end else begin
            case (state_r)
                iam_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_r <= iam_pkg::ST_ISSUE;
                    end
                end
                iam_pkg::ST_ISSUE: begin
                    if (dec_r.region == iam_pkg::IAM_RG_PFM) begin
                        state_r <= iam_pkg::ST_FLASH_WAIT;
                    end else begin
                        state_r <= iam_pkg::ST_RESP;
                    end
                end
                iam_pkg::ST_FLASH_WAIT: begin
                    state_r <= iam_pkg::ST_RESP;
                end
                default: begin
                    state_r <= iam_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // capture the decoded request
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            dec_r <= '0;
            wr_r  <= 1'b0;
        end else if (accept) begin
            dec_r <= dec;
            wr_r  <= i_req.wr;
        end
    end

    // data memory strobe, one cycle after the request
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            dmem_req_r   <= 1'b0;
            dmem_wr_r    <= 1'b0;
            dmem_addr_r  <= '0;
            dmem_wdata_r <= '0;
        end else begin
            dmem_req_r <= accept && data_hit;
            dmem_wr_r  <= accept && data_hit && i_req.wr;
            if (accept) begin
                dmem_addr_r  <= dec.daddr;
                dmem_wdata_r <= i_req.wdata;
            end
        end
    end

    // flash read strobe, never for a write
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pfm_req_r  <= 1'b0;
            pfm_addr_r <= '0;
        end else begin
            pfm_req_r <= accept && !i_req.wr &&
                         dec.region == iam_pkg::IAM_RG_PFM;
            if (accept) begin
                pfm_addr_r <= dec.paddr;
            end
        end
    end

    // busy and the extra flash cycle stall
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            busy_r  <= 1'b0;
            stall_r <= 1'b0;
        end else begin
            if (accept) begin
                busy_r <= 1'b1;
            end else if (state_r == iam_pkg::ST_RESP) begin
                busy_r <= 1'b0;
            end
            stall_r <= state_r == iam_pkg::ST_ISSUE &&
                       dec_r.region == iam_pkg::IAM_RG_PFM;
        end
    end

    // answer: read data and completion pulse
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            done_r  <= 1'b0;
            rdata_r <= iam_pkg::ZERO_DATA;
        end else begin
            done_r <= state_r == iam_pkg::ST_RESP;
            if (state_r == iam_pkg::ST_RESP) begin
                if (wr_r || dec_r.self_ref) begin
                    rdata_r <= iam_pkg::ZERO_DATA;
                end else if (dec_r.region == iam_pkg::IAM_RG_PFM) begin
                    rdata_r <= i_pfm_rdata[7:0];
                end else if (dec_r.region == iam_pkg::IAM_RG_NONE) begin
                    rdata_r <= iam_pkg::ZERO_DATA;
                end else begin
                    rdata_r <= i_dmem_rdata;
                end
            end
        end
    end

    // outputs straight from flip-flops
    assign o_busy       = busy_r;
    assign o_stall      = stall_r;
    assign o_done       = done_r;
    assign o_rdata      = rdata_r;
    assign o_dmem_req   = dmem_req_r;
    assign o_dmem_wr    = dmem_wr_r;
    assign o_dmem_addr  = dmem_addr_r;
    assign o_dmem_wdata = dmem_wdata_r;
    assign o_pfm_req    = pfm_req_r;
    assign o_pfm_addr   = pfm_addr_r;

    // self reference never reaches data memory
    AST_SELF_NO_ACCESS: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && dec.self_ref |=> !o_dmem_req && !o_dmem_wr)
        else $error("self reference reached data memory");

    // self reference read answers zero after three cycles
    AST_SELF_READ_ZERO: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && dec.self_ref && !i_req.wr |-> ##3 (o_done && o_rdata == 8'h00))
        else $error("self reference read not zero");

    // data access strobes then completes
    AST_DATA_SEQ: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && data_hit |-> ##1 o_dmem_req ##1 !o_done ##1 o_done)
        else $error("data access sequence wrong");

    // traditional pointer reaches its absolute address
    AST_TRAD_ADDR: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && data_hit && ptr <= 16'h0fff |=> o_dmem_addr == 12'($past(ptr)))
        else $error("traditional address wrong");

    // linear pointer lands inside a bank ram block
    AST_LIN_BLOCK: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && dec.region == iam_pkg::IAM_RG_LIN |=>
            o_dmem_req && o_dmem_addr[6:0] >= 7'h20 && o_dmem_addr[6:0] <= 7'h6f)
        else $error("linear address outside ram block");

    // flash write causes no memory strobe of any kind
    AST_FLASH_NO_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && i_req.wr && ptr[15] |=> !o_pfm_req && !o_dmem_req)
        else $error("flash write produced an access");

    // flash access completes one cycle later, stalling in between
    AST_FLASH_EXTRA: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && ptr[15] |-> ##2 o_stall ##1 !o_done ##1 o_done)
        else $error("flash extra cycle missing");

    // flash read addresses the low 15 pointer bits
    AST_PFM_ADDR: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && !i_req.wr && ptr[15] |=> o_pfm_req && o_pfm_addr == 15'($past(ptr)))
        else $error("flash address wrong");

    // unimplemented space reads zero without touching memory
    AST_UNIMP_ZERO: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && dec.region == iam_pkg::IAM_RG_NONE |->
            ##1 !o_dmem_req ##2 (o_done && o_rdata == 8'h00))
        else $error("unimplemented space not zero");

    // busy is already low in the completion cycle
    AST_DONE_NOT_BUSY: assert property (@(posedge i_clock) disable iff (i_rst)
        o_done |-> !o_busy)
        else $error("busy still high at completion");

    // completion is a single cycle pulse
    AST_DONE_PULSE: assert property (@(posedge i_clock) disable iff (i_rst)
        o_done |=> !o_done)
        else $error("completion longer than one cycle");

    // the extra flash cycle is a single cycle stall
    AST_STALL_PULSE: assert property (@(posedge i_clock) disable iff (i_rst)
        o_stall |=> !o_stall)
        else $error("stall longer than one cycle");

    // data space accesses never stall
    AST_DATA_NO_STALL: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && !ptr[15] |-> ##2 !o_stall)
        else $error("data access stalled");

    // a data write carries the core's write data
    AST_WRITE_DATA: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && data_hit && i_req.wr |=> o_dmem_wr && o_dmem_wdata == $past(i_req.wdata))
        else $error("write data wrong");

    // a read never raises the write enable
    AST_READ_NO_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && !i_req.wr |=> !o_dmem_wr)
        else $error("read raised write enable");

    // flash read answers the low byte of the word
    AST_FLASH_LOW_BYTE: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && !i_req.wr && ptr[15] |-> ##4 (o_done && o_rdata == 8'($past(i_pfm_rdata))))
        else $error("flash read byte wrong");

    // linear region never reaches the common bytes
    AST_LIN_NO_COMMON: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && dec.region == iam_pkg::IAM_RG_LIN |=> !(o_dmem_addr[6:0] >= 7'h70))
        else $error("linear region reached common memory");

    // unimplemented space is never written
    AST_UNIMP_NO_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
        accept && dec.region == iam_pkg::IAM_RG_NONE |=> !o_dmem_wr && !o_pfm_req)
        else $error("unimplemented space was accessed");

    // no strobe or stall outside a busy access
    AST_IDLE_QUIET: assert property (@(posedge i_clock) disable iff (i_rst)
        !o_busy |-> !o_stall && !o_dmem_req && !o_pfm_req)
        else $error("strobe while not busy");

    // an accepted request raises busy
    AST_BUSY_RISE: assert property (@(posedge i_clock) disable iff (i_rst)
        accept |=> o_busy)
        else $error("busy missing after accept");

endmodule

// >>> test/iam_mem_model.sv
// data memory and program flash that answer the mapper's strobes
`timescale 1ns/1ps
module iam_mem_model (
    // clock
    input  wire logic        i_clock,
    // data memory port
    input  wire logic        i_dmem_req,
    input  wire logic [11:0] i_dmem_addr,
    output logic      [7:0]  o_dmem_rdata,
    // program flash port
    input  wire logic        i_pfm_req,
    input  wire logic [14:0] i_pfm_addr,
    output logic      [13:0] o_pfm_rdata
);
    logic        pfm_d1_r;
    logic [14:0] pfm_addr_r;

    // contents are a pattern of the address so a wrong address shows up
    function automatic logic [7:0] dval(input logic [11:0] a);
        dval = a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5a;
    endfunction

    // flash words carry non-zero upper bits to expose a wide read
    function automatic logic [13:0] fval(input logic [14:0] a);
        fval = {a[13:8] ^ 6'h2a, a[7:0] ^ 8'hc3};
    endfunction

    // known start values
    initial begin
        o_dmem_rdata = 8'h00;
        o_pfm_rdata  = 14'h0000;
        pfm_d1_r     = 1'h0;
        pfm_addr_r   = 15'h0000;
    end

    // data valid one cycle after the strobe, flash two; otherwise inverted garbage
    always @(posedge i_clock) begin
        o_dmem_rdata <= (i_dmem_req === 1'h1) ? dval(i_dmem_addr) : ~o_dmem_rdata;
        pfm_d1_r     <= i_pfm_req;
        pfm_addr_r   <= i_pfm_addr;
        o_pfm_rdata  <= (pfm_d1_r === 1'h1) ? fval(pfm_addr_r) : ~o_pfm_rdata;
    end
endmodule

// >>> test/tb_iam_mapper.sv
// self-checking bench for the indirect address mapper
`timescale 1ns/1ps
module tb_iam_mapper;
    // one access: pointer, pair, direction, data, kind (0 none 1 rd 2 wr 3 flash rd 4 flash wr)
    typedef struct packed {
        logic [15:0] ptr;
        logic        sel;
        logic        wr;
        logic [7:0]  wd;
        logic [2:0]  kind;
        logic [11:0] addr;
    } iam_row_s;

    localparam iam_row_s ROWS [17] = '{
        '{16'h0123, 1'h0, 1'h0, 8'h00, 3'h1, 12'h123},
        '{16'h0fff, 1'h1, 1'h0, 8'h00, 3'h1, 12'hfff},
        '{16'h0045, 1'h0, 1'h1, 8'h9e, 3'h2, 12'h045},
        '{16'h0000, 1'h0, 1'h0, 8'h00, 3'h0, 12'h000},
        '{16'h0081, 1'h1, 1'h1, 8'h77, 3'h0, 12'h000},
        '{16'h0f80, 1'h0, 1'h0, 8'h00, 3'h0, 12'h000},
        '{16'h2000, 1'h0, 1'h0, 8'h00, 3'h1, 12'h020},
        '{16'h204f, 1'h1, 1'h0, 8'h00, 3'h1, 12'h06f},
        '{16'h2050, 1'h0, 1'h0, 8'h00, 3'h1, 12'h0a0},
        '{16'h29af, 1'h1, 1'h0, 8'h00, 3'h1, 12'hf6f},
        '{16'h2051, 1'h0, 1'h1, 8'h3c, 3'h2, 12'h0a1},
        '{16'h1000, 1'h0, 1'h0, 8'h00, 3'h0, 12'h000},
        '{16'h29b0, 1'h1, 1'h0, 8'h00, 3'h0, 12'h000},
        '{16'h7fff, 1'h0, 1'h1, 8'h11, 3'h0, 12'h000},
        '{16'h8000, 1'h0, 1'h0, 8'h00, 3'h3, 12'h000},
        '{16'hffff, 1'h1, 1'h0, 8'h00, 3'h3, 12'h000},
        '{16'h8123, 1'h0, 1'h1, 8'h55, 3'h4, 12'h000}
    };

    logic               i_clock = 1'h0;
    logic               i_rst   = 1'h1;
    logic [1:0][7:0]    ptr_hi  = '0;
    logic [1:0][7:0]    ptr_lo  = '0;
    iam_pkg::iam_req_s  req     = '0;
    logic               o_busy, o_stall, o_done, o_dmem_req, o_dmem_wr, o_pfm_req;
    logic [7:0]         o_rdata, o_dmem_wdata, dmem_rdata, dm_wd, ex;
    logic [11:0]        o_dmem_addr, dm_addr;
    logic [14:0]        o_pfm_addr, pf_addr;
    logic [13:0]        pfm_rdata, fw;
    logic               dm_wr, bz;
    int                 n_fail = 0, n_tests = 0, n_dm = 0, n_pf = 0, n_st = 0, cyc;
    iam_row_s           r;
    logic [2:0]         k;

    // device under test and its memories
    iam_mapper DUT (.i_clock(i_clock), .i_rst(i_rst), .i_pointer_high_byte(ptr_hi),
        .i_pointer_low_byte(ptr_lo), .i_req(req), .o_busy(o_busy), .o_stall(o_stall),
        .o_done(o_done), .o_rdata(o_rdata), .o_dmem_req(o_dmem_req), .o_dmem_wr(o_dmem_wr),
        .o_dmem_addr(o_dmem_addr), .o_dmem_wdata(o_dmem_wdata), .i_dmem_rdata(dmem_rdata),
        .o_pfm_req(o_pfm_req), .o_pfm_addr(o_pfm_addr), .i_pfm_rdata(pfm_rdata));
    iam_mem_model MEM (.i_clock(i_clock), .i_dmem_req(o_dmem_req), .i_dmem_addr(o_dmem_addr),
        .o_dmem_rdata(dmem_rdata), .i_pfm_req(o_pfm_req), .i_pfm_addr(o_pfm_addr),
        .o_pfm_rdata(pfm_rdata));

    // 125 MHz clock
    always #4 i_clock = ~i_clock;

    // record strobes and what they carried
    always @(posedge i_clock) begin
        if (o_dmem_req === 1'h1) begin
            n_dm++;
            dm_wr   = o_dmem_wr;
            dm_addr = o_dmem_addr;
            dm_wd   = o_dmem_wdata;
        end
        if (o_pfm_req === 1'h1) begin
            n_pf++;
            pf_addr = o_pfm_addr;
        end
        if (o_stall === 1'h1) n_st++;
    end

    // memory patterns as the model holds them
    function automatic logic [7:0] dval(input logic [11:0] a);
        dval = a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5a;
    endfunction
    function automatic logic [13:0] fval(input logic [14:0] a);
        fval = {a[13:8] ^ 6'h2a, a[7:0] ^ 8'hc3};
    endfunction

    // compare and count
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // counts and verdict, then stop
    task automatic results();
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // every output is low while in reset
    task automatic quiet();
        chk(64'({o_busy, o_stall, o_done, o_dmem_req, o_dmem_wr, o_pfm_req, o_rdata,
                 o_dmem_wdata, o_dmem_addr, o_pfm_addr}), 64'h0);
    endtask

    // one request; twice repeats valid while busy with another pointer
    task automatic access(input iam_row_s a, input logic twice, output int n);
        @(posedge i_clock);
        n_dm = 0;
        n_pf = 0;
        n_st = 0;
        ptr_hi[a.sel]  <= a.ptr[15:8];
        ptr_lo[a.sel]  <= a.ptr[7:0];
        ptr_hi[~a.sel] <= ~a.ptr[15:8];
        ptr_lo[~a.sel] <= ~a.ptr[7:0];
        req <= '{valid: 1'h1, wr: a.wr, sel: a.sel, wdata: a.wd};
        n = 0;
        do begin
            @(posedge i_clock);
            req.valid <= (n == 0) && twice;
            if (n == 0 && twice) ptr_lo[a.sel] <= 8'h33;
            n++;
            #1;
            if (n == 1) bz = o_busy;
        end while (o_done !== 1'h1 && n < 12);
        if (o_done !== 1'h1) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, o_done, 1'h1);
            results();
        end
    endtask

    initial begin
        repeat (4) @(posedge i_clock);
        #1;
        quiet();
        @(posedge i_clock);
        i_rst <= 1'h0;
        // table of ordinary accesses
        for (int i = 0; i < 17; i++) begin
            r = ROWS[i];
            k = r.kind;
            access(r, 1'h0, cyc);
            fw = fval(r.ptr[14:0]);
            ex = (k == 3'h1) ? dval(r.addr) : (k == 3'h3) ? fw[7:0] : 8'h00;
            chk(64'(cyc), (k > 3'h2) ? 64'h4 : 64'h3);
            chk(64'({bz, o_busy}), 64'h2);
            chk(64'(o_rdata), 64'(ex));
            chk(64'(n_dm), 64'(k == 3'h1 || k == 3'h2));
            chk(64'(n_st), 64'(k > 3'h2));
            if (k == 3'h1 || k == 3'h2) begin
                chk(64'({dm_wr, dm_addr}), 64'({k == 3'h2, r.addr}));
            end
            if (k == 3'h2) chk(64'(dm_wd), 64'(r.wd));
            chk(64'(n_pf), 64'(k == 3'h3));
            if (k == 3'h3) chk(64'(pf_addr), 64'(r.ptr[14:0]));
        end
        // a second valid while busy is ignored
        access(ROWS[0], 1'h1, cyc);
        chk(64'({dm_addr, o_rdata}), 64'({12'h123, dval(12'h123)}));
        repeat (4) @(posedge i_clock);
        chk(64'(n_dm), 64'h1);
        // reset in the middle of a flash access
        @(posedge i_clock);
        ptr_hi[0] <= 8'h80;
        ptr_lo[0] <= 8'h00;
        req <= '{valid: 1'h1, wr: 1'h0, sel: 1'h0, wdata: 8'h00};
        @(posedge i_clock);
        req.valid <= 1'h0;
        i_rst <= 1'h1;
        repeat (2) @(posedge i_clock);
        #1;
        quiet();
        @(posedge i_clock);
        i_rst <= 1'h0;
        access(ROWS[8], 1'h0, cyc);
        chk(64'({dm_addr, o_rdata}), 64'({12'h0a0, dval(12'h0a0)}));
        results();
    end
endmodule
